// ---- core/output_protect_map.vh ----
// register offsets, field positions, reset values and timing counts for the
// complementary output protection stage; definitions only
`ifndef OUTPUT_PROTECT_MAP_VH
`define OUTPUT_PROTECT_MAP_VH

// protection register byte offset
`define OPC_OFFSET 12'h044
// second control register and channel enable register (own offsets)
`define CTL1_OFFSET 12'h004
`define CHEN_OFFSET 12'h020
// compare mode register (own offset)
`define CMODE_OFFSET 12'h018
// status register (own offset)
`define STAT_OFFSET 12'h100
`define OPC_RESET 32'h00000000

// field positions of the protection register
`define GATE_BIT 15
`define REARM_BIT 14
`define FPOL_BIT 13
`define FEN_BIT 12
`define ROS_BIT 11
`define IOS_BIT 10
`define LOCK_HI 9
`define LOCK_LO 8
`define DT_HI 7
`define DT_LO 0

// lock levels
`define LOCK_NONE 2'h0
`define LOCK_L1 2'h1
`define LOCK_L2 2'h2
`define LOCK_L3 2'h3

// base dead-time tick in timer clocks
`define DT_TICK_CYCLES 4'h1
`endif

// ---- core/dead_time_gen.v ----
// dead-time insertion for one complementary pair.
// assumes a single clock and a synchronous reset copy from the top.
`timescale 1ns/10ps
module dead_time_gen (
  clk,
  rstSync_n,
  tickEn,
  deadCycles,
  refIn,
  mainOut,
  invOut
);
  input wire clk;
  input wire rstSync_n;
  input wire tickEn;
  input wire [12:0] deadCycles;
  input wire refIn;
  output reg mainOut;
  output reg invOut;

  reg refPrev_r;
  reg [12:0] cnt_r;

  // both legs low while the counter runs; the new leg rises after it expires
  always @(posedge clk) begin
    if (!rstSync_n) begin
      refPrev_r <= 1'b0;
      cnt_r <= 13'h0000;
      mainOut <= 1'b0;
      invOut <= 1'b0;
    end else begin
      refPrev_r <= refIn;
      if (refIn != refPrev_r) begin
        mainOut <= 1'b0;
        invOut <= 1'b0;
        cnt_r <= deadCycles;
      end else if (cnt_r != 13'h0000) begin
        if (tickEn) begin
          cnt_r <= cnt_r - 13'h0001;
        end
      end else begin
        mainOut <= refIn;
        invOut <= ~refIn;
      end
    end
  end
endmodule

// ---- core/output_protect.v ----
// complementary output protection: master gate, fault input, off-states,
// write lock and dead time for four channel pairs, behind an apb slave.
// assumes the update input is synchronous to clk; the fault input is resynchronised.
// clock failure arrives as a level already in this domain and is not resynchronised.
// limitation: a fault pulse shorter than one clock may slip past the synchroniser.
`timescale 1ns/10ps
`include "output_protect_map.vh"
module output_protect (
  clk,
  rst_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  faultInput,
  clockFailure,
  updateEvent,
  channelRef,
  channelOutput,
  channelOutputOe,
  channelInvertedOutput,
  channelInvertedOutputOe
);
  input wire clk;
  input wire rst_n;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire faultInput;
  input wire clockFailure;
  input wire updateEvent;
  input wire [3:0] channelRef;
  output reg [3:0] channelOutput;
  output reg [3:0] channelOutputOe;
  output reg [3:0] channelInvertedOutput;
  output reg [3:0] channelInvertedOutputOe;

  reg rstMeta_r;
  reg rstSync_r;
  reg faultMeta_r;
  reg faultSync_r;
  reg masterGate_r;
  reg autoRearm_r;
  reg faultPolarity_r;
  reg faultEnable_r;
  reg runOffstate_r;
  reg idleOffstate_r;
  reg [1:0] lockLevel_r;
  reg lockWritten_r;
  reg [7:0] deadTimeCode_r;
  reg [3:0] idleLevel_r;
  reg [3:0] invIdleLevel_r;
  reg [3:0] chanEnable_r;
  reg [3:0] invEnable_r;
  reg [3:0] chanPolarity_r;
  reg [3:0] invPolarity_r;
  reg [15:0] compareMode_r;
  reg [3:0] shadowEnable_r;
  reg [3:0] chanIsOutput_r;
  reg [12:0] deadCycles_r;
  reg [3:0] tickCnt_r;
  reg tickEn_r;
  wire rstSync_n;
  wire faultActive;
  wire faultValid;
  wire wrAccess;
  wire [3:0] dtMain;
  wire [3:0] dtInv;
  // leg values and drive enables ahead of the output flops
  wire [3:0] mainLeg_nxt;
  wire [3:0] mainOe_nxt;
  wire [3:0] invLeg_nxt;
  wire [3:0] invOe_nxt;
  integer i;

  // reset released through two flops so every flop leaves reset together
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  assign rstSync_n = rstSync_r;

  always @(posedge clk) begin
    if (!rstSync_n) begin
      faultMeta_r <= 1'b0;
      faultSync_r <= 1'b0;
    end else begin
      faultMeta_r <= faultInput;
      faultSync_r <= faultMeta_r;
    end
  end

  assign faultActive = faultPolarity_r ? faultSync_r : ~faultSync_r;
  assign faultValid = faultEnable_r & (faultActive | clockFailure);

  // apb: zero wait states, unmapped addresses read zero without error
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrAccess = psel & penable & pwrite;

  // decodes a word offset, shared by write and read paths
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr[11:2] == off[11:2]);
    end
  endfunction

  // true while fields of the given protection tier may still be written
  function writable;
    input [1:0] level;
    input [1:0] tier;
    begin
      writable = (level < tier);
    end
  endfunction

  // protection register: gate events, lock-filtered fields, one-shot lock
  always @(posedge clk) begin
    if (!rstSync_n) begin
      masterGate_r <= 1'b0;
      autoRearm_r <= 1'b0;
      faultPolarity_r <= 1'b0;
      faultEnable_r <= 1'b0;
      runOffstate_r <= 1'b0;
      idleOffstate_r <= 1'b0;
      lockLevel_r <= `LOCK_NONE;
      lockWritten_r <= 1'b0;
      deadTimeCode_r <= 8'h00;
    end else begin
      if (wrAccess && hit(paddr, `OPC_OFFSET)) begin
        masterGate_r <= pwdata[`GATE_BIT];
        if (writable(lockLevel_r, `LOCK_L1)) begin
          autoRearm_r <= pwdata[`REARM_BIT];
          faultPolarity_r <= pwdata[`FPOL_BIT];
          faultEnable_r <= pwdata[`FEN_BIT];
          deadTimeCode_r <= pwdata[`DT_HI:`DT_LO];
        end
        if (writable(lockLevel_r, `LOCK_L2)) begin
          runOffstate_r <= pwdata[`ROS_BIT];
          idleOffstate_r <= pwdata[`IOS_BIT];
        end
        // one write only
        // other fields of this same write still obey the old level
        if (!lockWritten_r) begin
          lockLevel_r <= pwdata[`LOCK_HI:`LOCK_LO];
          lockWritten_r <= 1'b1;
        end
      end else if (updateEvent && autoRearm_r && !faultValid) begin
        masterGate_r <= 1'b1;
      end
      // fault clear wins over any set
      if (faultValid) begin
        masterGate_r <= 1'b0;
      end
    end
  end

  // neighbour control bits; the lock protects idle levels, polarity and compare fields
  always @(posedge clk) begin
    if (!rstSync_n) begin
      idleLevel_r <= 4'h0;
      invIdleLevel_r <= 4'h0;
      chanEnable_r <= 4'h0;
      invEnable_r <= 4'h0;
      chanPolarity_r <= 4'h0;
      invPolarity_r <= 4'h0;
      compareMode_r <= 16'h0000;
      shadowEnable_r <= 4'h0;
      chanIsOutput_r <= 4'hf;
    end else if (wrAccess) begin
      // idle levels locked from level one
      if (hit(paddr, `CTL1_OFFSET) && writable(lockLevel_r, `LOCK_L1)) begin
        idleLevel_r <= pwdata[3:0];
        invIdleLevel_r <= pwdata[7:4];
      end
      if (hit(paddr, `CHEN_OFFSET)) begin
        chanEnable_r <= pwdata[3:0];
        invEnable_r <= pwdata[7:4];
        chanIsOutput_r <= pwdata[19:16];
        for (i = 0; i < 4; i = i + 1) begin
          // polarity locked for output channels
          // the old output-mode flag decides, so a write cannot unlock itself
          if (writable(lockLevel_r, `LOCK_L2) || !chanIsOutput_r[i]) begin
            chanPolarity_r[i] <= pwdata[8 + i];
            invPolarity_r[i] <= pwdata[12 + i];
          end
        end
      end
      if (hit(paddr, `CMODE_OFFSET)) begin
        for (i = 0; i < 4; i = i + 1) begin
          // compare fields locked at level three
          if (writable(lockLevel_r, `LOCK_L3) || !chanIsOutput_r[i]) begin
            compareMode_r[4*i +: 4] <= pwdata[4*i +: 4];
            shadowEnable_r[i] <= pwdata[16 + i];
          end
        end
      end
    end
  end

  // read mux; reserved bits read zero
  // the status word is read only, writes to its offset are dropped
  always @* begin
    prdata = 32'h00000000;
    if (hit(paddr, `OPC_OFFSET)) begin
      prdata[`GATE_BIT] = masterGate_r;
      prdata[`REARM_BIT] = autoRearm_r;
      prdata[`FPOL_BIT] = faultPolarity_r;
      prdata[`FEN_BIT] = faultEnable_r;
      prdata[`ROS_BIT] = runOffstate_r;
      prdata[`IOS_BIT] = idleOffstate_r;
      prdata[`LOCK_HI:`LOCK_LO] = lockLevel_r;
      prdata[`DT_HI:`DT_LO] = deadTimeCode_r;
    end else if (hit(paddr, `CTL1_OFFSET)) begin
      prdata[7:0] = {invIdleLevel_r, idleLevel_r};
    end else if (hit(paddr, `CHEN_OFFSET)) begin
      prdata[19:0] = {chanIsOutput_r, invPolarity_r, chanPolarity_r, invEnable_r, chanEnable_r};
    end else if (hit(paddr, `CMODE_OFFSET)) begin
      prdata[19:0] = {shadowEnable_r, compareMode_r};
    end else if (hit(paddr, `STAT_OFFSET)) begin
      prdata[2:0] = {lockWritten_r, faultValid, faultSync_r};
    end
  end

  // code to tick count, registered to keep the decode off the count path
  // the widest code gives 63 times sixteen ticks, so 13 bits leave headroom
  always @(posedge clk) begin
    if (!rstSync_n) begin
      deadCycles_r <= 13'h0000;
    end else if (deadTimeCode_r[7] == 1'b0) begin
      deadCycles_r <= {5'h00, deadTimeCode_r};
    end else if (deadTimeCode_r[6] == 1'b0) begin
      deadCycles_r <= {4'h0, 3'h1, deadTimeCode_r[5:0]} << 1;
    end else if (deadTimeCode_r[5] == 1'b0) begin
      deadCycles_r <= {5'h00, 3'h1, deadTimeCode_r[4:0]} << 3;
    end else begin
      deadCycles_r <= {5'h00, 3'h1, deadTimeCode_r[4:0]} << 4;
    end
  end

  // base dead-time tick enable from a divider
  // a tick count of one yields an enable on every clock after reset
  always @(posedge clk) begin
    if (!rstSync_n) begin
      tickCnt_r <= 4'h0;
      tickEn_r <= 1'b0;
    end else if (tickCnt_r + 4'h1 >= `DT_TICK_CYCLES) begin
      tickCnt_r <= 4'h0;
      tickEn_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 4'h1;
      tickEn_r <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pair
      dead_time_gen dead_time_gen_i (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .tickEn(tickEn_r),
        .deadCycles(deadCycles_r),
        .refIn(channelRef[g]),
        .mainOut(dtMain[g]),
        .invOut(dtInv[g])
      );
    end
  endgenerate

  // gate picks run or idle legs
  generate
    for (g = 0; g < 4; g = g + 1) begin : legSel
      // run legs: enabled follows dead time, else off-state or released
      assign mainLeg_nxt[g] = masterGate_r ?
        (chanEnable_r[g] ? dtMain[g] ^ chanPolarity_r[g] : chanPolarity_r[g]) : idleLevel_r[g];
      assign invLeg_nxt[g] = masterGate_r ?
        (invEnable_r[g] ? dtInv[g] ^ invPolarity_r[g] : invPolarity_r[g]) : invIdleLevel_r[g];
      // idle drive: off-state bit, or either enable of the pair
      assign mainOe_nxt[g] = masterGate_r ? (chanEnable_r[g] | runOffstate_r)
                                          : (idleOffstate_r | chanEnable_r[g] | invEnable_r[g]);
      assign invOe_nxt[g] = masterGate_r ? (invEnable_r[g] | runOffstate_r)
                                         : (idleOffstate_r | chanEnable_r[g] | invEnable_r[g]);
    end
  endgenerate

  // legs leave through flops so a decode glitch never reaches the power stage
  always @(posedge clk) begin
    if (!rstSync_n) begin
      channelOutput <= 4'h0;
      channelOutputOe <= 4'h0;
      channelInvertedOutput <= 4'h0;
      channelInvertedOutputOe <= 4'h0;
    end else begin
      channelOutput <= mainLeg_nxt;
      channelOutputOe <= mainOe_nxt;
      channelInvertedOutput <= invLeg_nxt;
      channelInvertedOutputOe <= invOe_nxt;
    end
  end
endmodule

// ---- verif/output_protect_asserts.sv ----
// checker for the output protection stage, bound to its top module
// assumes word-aligned apb accesses and one clock domain
`timescale 1ns/10ps
`include "output_protect_map.vh"
module output_protect_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic faultInput,
  input wire logic clockFailure,
  input wire logic updateEvent
);
  logic [31:0] shadow_r;
  logic [1:0] lock_r;
  logic lockSeen_r;
  logic [31:0] maskNow;
  logic wrOpc, rdOpc, act, quiet;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // fields open under the lock level in force before the write
  assign maskNow = (!lockSeen_r || lock_r == 2'h0) ? 32'h00007cff :
                   (lock_r == 2'h1) ? 32'h00000c00 : 32'h00000000;
  assign wrOpc = psel && penable && pwrite && paddr == `OPC_OFFSET;
  assign rdOpc = psel && !pwrite && paddr == `OPC_OFFSET;
  assign act = faultInput == shadow_r[`FPOL_BIT];
  assign quiet = !(shadow_r[`FEN_BIT] && (act || clockFailure));
  // shadow of protected fields; lock taken from the first write only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_r <= 32'h0;
      lock_r <= 2'h0;
      lockSeen_r <= 1'b0;
    end else if (wrOpc) begin
      shadow_r <= (shadow_r & ~maskNow) | (pwdata & maskNow);
      lockSeen_r <= 1'b1;
      if (!lockSeen_r) begin
        lock_r <= pwdata[9:8];
      end
    end
  end
  reserved_bits_a: assert property (rdOpc |-> prdata[31:16] == 16'h0)
    else $error("reserved bits read nonzero");
  lock_once_a: assert property (lockSeen_r && rdOpc |-> prdata[9:8] == lock_r)
    else $error("lock level changed after first write");
  lock_one_fields_a: assert property (rdOpc |->
    prdata[14:12] == shadow_r[14:12] && prdata[7:0] == shadow_r[7:0])
    else $error("level one field write handled wrongly");
  offstate_lock_a: assert property (rdOpc |-> prdata[11:10] == shadow_r[11:10])
    else $error("off-state field write handled wrongly");
  fault_clear_a: assert property ((shadow_r[`FEN_BIT] && act)[*2] ##1 !wrOpc
    ##1 rdOpc |-> !prdata[15])
    else $error("fault did not clear gate");
  clock_fail_a: assert property (shadow_r[`FEN_BIT] && clockFailure ##1 !wrOpc
    ##1 rdOpc |-> !prdata[15])
    else $error("clock failure did not clear gate");
  rearm_set_a: assert property (quiet[*4] ##0 (shadow_r[`REARM_BIT] && updateEvent
    && !wrOpc) ##1 (quiet && !wrOpc) ##1 rdOpc |-> prdata[15])
    else $error("update did not re-arm gate");
  unmapped_read_a: assert property (psel && !pwrite && paddr == 12'h040
    |-> prdata == 32'h0)
    else $error("unmapped read nonzero");
  cover property (wrOpc && lockSeen_r);
  cover property ((shadow_r[`FEN_BIT] && act)[*2]);
  cover property (shadow_r[`REARM_BIT] && updateEvent);
endmodule
bind output_protect output_protect_asserts output_protect_asserts_i (.clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .faultInput, .clockFailure, .updateEvent);

// ---- verif/power_stage.sv ----
// power stage model: drives the fault line, watches each leg pair
// assumes the bench sets trip request and polarity at clock edges
`timescale 1ns/10ps
module power_stage (
  input wire logic tripReq,
  input wire logic polHigh,
  input wire logic [3:0] mainLeg,
  input wire logic [3:0] mainOe,
  input wire logic [3:0] invLeg,
  input wire logic [3:0] invOe,
  output logic faultInput,
  output logic shortSeen
);
  // fault level follows the polarity chosen
  assign faultInput = tripReq ? polHigh : !polHigh;
  // both switches on at once would short the rail
  initial shortSeen = 1'b0;
  always @(mainLeg or mainOe or invLeg or invOe) begin
    if (|(mainLeg & mainOe & invLeg & invOe) === 1'b1) shortSeen = 1'b1;
  end
endmodule

// ---- verif/output_protect_test.sv ----
// self-checking bench for the output protection stage
// assumes zero-wait apb answers and a 250 MHz clock
`timescale 1ns/10ps
`include "output_protect_map.vh"
module output_protect_test;
  logic clk, rst_n, psel, penable, pwrite, clockFailure, updateEvent, pready, pslverr;
  logic tripReq, polHigh, faultInput, shortSeen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rdErr;
  logic [3:0] channelRef, channelOutput, channelOutputOe;
  logic [3:0] channelInvertedOutput, channelInvertedOutputOe;
  logic [15:0] legs;
  int error_cnt, tests_run;
  assign legs = {channelOutputOe, channelInvertedOutputOe, channelOutput, channelInvertedOutput};
  output_protect output_protect_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .faultInput, .clockFailure, .updateEvent, .channelRef,
    .channelOutput, .channelOutputOe, .channelInvertedOutput, .channelInvertedOutputOe);
  power_stage power_stage_i (.tripReq, .polHigh, .mainLeg(channelOutput),
    .mainOe(channelOutputOe), .invLeg(channelInvertedOutput),
    .invOe(channelInvertedOutputOe), .faultInput, .shortSeen);
  // free-running 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // whole words only, reserved bits left at zero
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(what, e, rd & m);
    chk("bus error", 32'h0, {31'h0, rdErr});
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // trip held for the given number of clocks
  task trip(input int n);
    @(posedge clk);
    tripReq <= 1'b1;
    repeat (n) @(posedge clk);
    tripReq <= 1'b0;
  endtask
  task pulse(input logic upd);
    @(posedge clk);
    if (upd) updateEvent <= 1'b1;
    else clockFailure <= 1'b1;
    @(posedge clk);
    updateEvent <= 1'b0;
    clockFailure <= 1'b0;
  endtask
  task t_reset;
    rdchk("protect reset", `OPC_OFFSET, 32'hffffffff, `OPC_RESET);
    rdchk("unmapped read", 12'h040, 32'hffffffff, 32'h0);
    rdchk("status reset", `STAT_OFFSET, 32'hfffffffe, 32'h0);
    chk("legs after reset", 32'h0, {16'h0, legs});
  endtask
  task t_states;
    static logic [31:0] cfg [4] = '{32'h8000, 32'h8800, 32'h0000, 32'h0400};
    static logic [15:0] exp [4] = '{16'h1110, 16'hff10, 16'h1100, 16'hff00};
    apb(`CHEN_OFFSET, 1'b1, 32'h000f0011);
    channelRef <= 4'h1;
    for (int i = 0; i < 4; i++) begin
      apb(`OPC_OFFSET, 1'b1, cfg[i]);
      wait_n(4);
      chk("leg states", {16'h0, exp[i]}, {16'h0, legs});
    end
  endtask
  task t_fault;
    for (int p = 0; p < 2; p++) begin
      polHigh <= p[0];
      apb(`OPC_OFFSET, 1'b1, 32'h1000 | (p << 13));
      wait_n(4);
      apb(`OPC_OFFSET, 1'b1, 32'h9000 | (p << 13));
      rdchk("gate set", `OPC_OFFSET, 32'h8000, 32'h8000);
      trip(2);
      wait_n(3);
      rdchk("fault clears gate", `OPC_OFFSET, 32'h8000, 32'h0);
    end
    apb(`OPC_OFFSET, 1'b1, 32'h8000);
    pulse(1'b0);
    rdchk("fault gated off", `OPC_OFFSET, 32'h8000, 32'h8000);
    polHigh <= 1'b0;
    apb(`OPC_OFFSET, 1'b1, 32'h9000);
    pulse(1'b0);
    rdchk("clock failure", `OPC_OFFSET, 32'h8000, 32'h0);
  endtask
  task t_rearm;
    apb(`OPC_OFFSET, 1'b1, 32'h4000);
    pulse(1'b1);
    rdchk("update re-arm", `OPC_OFFSET, 32'h8000, 32'h8000);
    apb(`OPC_OFFSET, 1'b1, 32'h5000);
    tripReq <= 1'b1;
    wait_n(4);
    pulse(1'b1);
    rdchk("re-arm in fault", `OPC_OFFSET, 32'h8000, 32'h0);
    tripReq <= 1'b0;
    apb(`OPC_OFFSET, 1'b1, 32'h1000);
    wait_n(4);
    pulse(1'b1);
    rdchk("re-arm off", `OPC_OFFSET, 32'h8000, 32'h0);
  endtask
  task dead(input logic [7:0] code, output int n);
    apb(`OPC_OFFSET, 1'b1, {16'h0, 8'h80, code});
    channelRef <= 4'h1;
    wait_n(600);
    @(posedge clk);
    channelRef <= 4'h0;
    n = 0;
    while (channelInvertedOutput[0] !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task t_dead;
    static logic [7:0] codes [6] = '{8'h01, 8'h05, 8'h81, 8'ha0, 8'hc1, 8'he0};
    static int ticks [6] = '{1, 5, 130, 192, 264, 512};
    int n0, n;
    dead(codes[0], n0);
    for (int i = 1; i < 6; i++) begin
      dead(codes[i], n);
      chk("dead time", ticks[i] - 1, n - n0);
    end
  endtask
  task t_lock;
    // the lock field took its one write earlier, so only a reset frees it again
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    apb(`OPC_OFFSET, 1'b1, 32'h00000322);
    apb(`CHEN_OFFSET, 1'b1, 32'h000f0f11);
    apb(`CMODE_OFFSET, 1'b1, 32'h000fffff);
    apb(`CTL1_OFFSET, 1'b1, 32'h000000ff);
    apb(`OPC_OFFSET, 1'b1, 32'h0000fd55);
    rdchk("protect locked", `OPC_OFFSET, 32'hffffffff, 32'h00008322);
    rdchk("polarity locked", `CHEN_OFFSET, 32'hffffffff, 32'h000f0011);
    rdchk("compare locked", `CMODE_OFFSET, 32'hffffffff, 32'h0);
    rdchk("idle locked", `CTL1_OFFSET, 32'hffffffff, 32'h0);
  endtask
  task finish_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence after a 12-cycle reset
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, clockFailure, updateEvent, tripReq, polHigh} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    channelRef = 4'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_states;
    t_fault;
    t_rearm;
    t_dead;
    t_lock;
    chk("no shoot-through", 32'h0, {31'h0, shortSeen});
    finish_test;
  end
  // watchdog well beyond the roughly 5000 cycles the tests take
  initial begin
    #100000;
    error_cnt++;
    finish_test;
  end
endmodule
